// >>> core/ccd_detect.sv
// current-detect engine: per-channel threshold compare, hit counting, window
`timescale 1ns/1ps
`default_nettype none
module ccd_detect #(
  parameter int NCH = 4
) (
  input wire logic clk_sys,                     // system clock
  input wire logic reset,                       // synchronous reset
  input wire logic clk_en,                      // freezes all state when low
  ccd_cfg_if.snk cfg,                           // detect configuration
  input wire logic conv_valid,                  // one conversion period done
  input wire logic [NCH*24-1:0] ch_result,      // signed results, channel 0 low
  output logic detect_q,                        // detection pulse
  output logic window_end_q                     // window closed pulse
);
  import ccd_pkg::*;

  logic [NCH-1:0] exceed;
  logic [11:0] win_cnt_q, win_cnt_d;
  logic [7:0] hit_cnt_q, hit_cnt_d;
  logic fired_q, fired_d, detect_d, window_end_d;
  logic hit, win_last;
  logic [7:0] need;
  logic [8:0] hit_sum;

  // ----------------------------------------------------------------
  // threshold compare per channel
  // ----------------------------------------------------------------
  // magnitude against threshold
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [CCD_RES_W-1:0] res, mag;
    assign res = ch_result[i*CCD_RES_W +: CCD_RES_W];
    assign mag = res[CCD_RES_W-1] ? CCD_RES_W'(~res + 1'b1) : res;
    assign exceed[i] = mag > cfg.threshold;
  end

  always_comb begin
    hit = cfg.policy ? &exceed : |exceed;
    need = CCD_HIT_UNIT << cfg.hit_code;
    win_last = win_cnt_q == 12'(CCD_WIN_TAB[cfg.win_code] - 12'h001);
    hit_sum = {1'b0, hit_cnt_q} + {8'h00, hit};
    win_cnt_d = win_cnt_q;
    hit_cnt_d = hit_cnt_q;
    fired_d = fired_q;
    detect_d = 1'b0;
    window_end_d = 1'b0;
    if (!cfg.en) begin
      win_cnt_d = 12'h000;
      hit_cnt_d = 8'h00;
      fired_d = 1'b0;
    end else if (conv_valid) begin
      hit_cnt_d = hit_sum[8] ? 8'hff : hit_sum[7:0];
      if (!fired_q && hit_cnt_d >= need) begin
        detect_d = 1'b1;
        fired_d = 1'b1;
      end
      win_cnt_d = win_cnt_q + 12'h001;
      if (win_last) begin
        window_end_d = 1'b1;
        win_cnt_d = 12'h000;
        hit_cnt_d = 8'h00;
        fired_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      win_cnt_q <= 12'h000;
      hit_cnt_q <= 8'h00;
      fired_q <= 1'b0;
      detect_q <= 1'b0;
      window_end_q <= 1'b0;
    end else if (clk_en) begin
      win_cnt_q <= win_cnt_d;
      hit_cnt_q <= hit_cnt_d;
      fired_q <= fired_d;
      detect_q <= detect_d;
      window_end_q <= window_end_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_detect_off_idle: assert property (clk_en && !cfg.en |=> !detect_q && win_cnt_q == 12'h000)
    else $error("detect activity while mode disabled");
  a_any_chan_fire: assert property (clk_en && cfg.en && !cfg.policy && conv_valid
      && |exceed && cfg.hit_code == 3'h0 && !fired_q |=> detect_q)
    else $error("single channel hit did not fire");
  a_all_chan_hold: assert property (clk_en && cfg.en && cfg.policy && conv_valid
      && !(&exceed) && !win_last |=> hit_cnt_q == $past(hit_cnt_q))
    else $error("partial hit counted under all-channel policy");
  // judged from registered counts, so a window closing with the last hit cannot trip it
  a_hit_need_met: assert property (clk_en && cfg.en && conv_valid && !fired_q
      && {1'b0, hit_cnt_q} + 9'h001 < {1'b0, need} |=> !detect_q)
    else $error("detection before enough hits");
  a_window_wrap_len: assert property (clk_en && cfg.en && conv_valid && win_last
      |=> window_end_q && win_cnt_q == 12'h000)
    else $error("window did not close at its length");
endmodule : ccd_detect
`default_nettype wire

// >>> core/ccd_top.sv
// chop and current-detect configuration block with avalon-mm register slave
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module ccd_top #(
  parameter int NCH = 4
) (
  input wire logic clk_sys,                              // system clock, 40 mhz
  input wire logic reset,                                // synchronous, active high
  input wire logic clk_en,                               // freezes all state when low
  input wire logic [ccd_pkg::CCD_ADDR_W-1:0] avs_address, // byte address
  input wire logic avs_read,                             // read request
  input wire logic avs_write,                            // write request
  input wire logic [31:0] avs_writedata,                 // write data
  input wire logic [3:0] avs_byteenable,                 // byte lanes
  output logic [31:0] avs_readdata,                      // read data
  output logic avs_waitrequest,                          // stall
  input wire logic mod_tick,                             // one modulator clock period
  input wire logic meas_req,                             // measurement wants to start
  input wire logic conv_valid,                           // conversion period done
  input wire logic [NCH*24-1:0] ch_result,               // channel results
  output logic meas_begin,                               // measurement may begin
  output logic chop_busy,                                // chop wait in progress
  output logic detect_pulse,                             // current detected
  output logic window_end                                // detect window closed
);
  import ccd_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [15:0] cfg_q, cfg_d, spare_q, spare_d, th_up_q, th_up_d;
  logic [7:0] th_lo_q, th_lo_d;
  logic det_flag_q, det_flag_d;
  logic waitreq_q, waitreq_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] rd_word;
  logic req, accept, commit, aligned;
  logic [5:0] idx;
  logic [15:0] wmask;

  ccd_cfg_if cfg_bus ();

  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] nw,
                                             input logic [15:0] mask);
    lane_merge = (old & ~mask) | (nw & mask);
  endfunction : lane_merge

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, write lands when waitrequest is low
  // ----------------------------------------------------------------
  always_comb begin
    req = avs_read | avs_write;
    accept = req & waitreq_q;
    commit = req & ~waitreq_q;
    idx = avs_address[CCD_ADDR_W-1:2];
    aligned = avs_address[1:0] == 2'h0;
    wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    unique case (idx)
      CCD_IDX_SPARE: rd_word = spare_q;
      CCD_IDX_CFG: rd_word = cfg_q;
      CCD_IDX_TH_UP: rd_word = th_up_q;
      CCD_IDX_TH_LO: rd_word = {th_lo_q, 8'h00};
      CCD_IDX_STAT: rd_word = {13'h0000, cfg_q[CCD_DET_EN_BIT], chop_busy, det_flag_q};
      default: rd_word = 16'h0000;
    endcase
    if (!aligned) begin
      rd_word = 16'h0000;
    end
    waitreq_d = ~accept;
    rdata_d = rdata_q;
    if (accept && avs_read) begin
      rdata_d = {16'h0000, rd_word};
    end
    cfg_d = cfg_q;
    spare_d = spare_q;
    th_up_d = th_up_q;
    th_lo_d = th_lo_q;
    // a new detection wins over a clear in the same cycle
    det_flag_d = det_flag_q;
    if (commit && avs_write && aligned) begin
      unique case (idx)
        CCD_IDX_SPARE: spare_d = lane_merge(spare_q, avs_writedata[15:0], wmask);
        CCD_IDX_CFG: cfg_d = lane_merge(cfg_q, avs_writedata[15:0], wmask);
        CCD_IDX_TH_UP: th_up_d = lane_merge(th_up_q, avs_writedata[15:0], wmask);
        CCD_IDX_TH_LO: th_lo_d = avs_byteenable[1] ? avs_writedata[15:CCD_TH_LO_LSB] : th_lo_q;
        CCD_IDX_STAT: begin
          if (avs_byteenable[0] && avs_writedata[CCD_ST_DET_BIT]) begin
            det_flag_d = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (detect_pulse) begin
      det_flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg_q <= CCD_CFG_RST;
      spare_q <= CCD_SPARE_RST;
      th_up_q <= CCD_TH_UP_RST;
      th_lo_q <= CCD_TH_LO_RST;
      det_flag_q <= 1'b0;
      waitreq_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      cfg_q <= cfg_d;
      spare_q <= spare_d;
      th_up_q <= th_up_d;
      th_lo_q <= th_lo_d;
      det_flag_q <= det_flag_d;
      waitreq_q <= waitreq_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest = waitreq_q;
  assign avs_readdata = rdata_q;

  // ----------------------------------------------------------------
  // chop settling wait
  // ----------------------------------------------------------------
  logic [CCD_CHOP_CNT_W-1:0] chop_cnt_q, chop_cnt_d, chop_load;
  logic chop_busy_d, meas_begin_d;

  always_comb begin
    chop_load = CCD_CHOP_UNIT << ({1'b0, cfg_q[CCD_DLY_MSB:CCD_DLY_LSB]} + 5'h01);
    chop_cnt_d = chop_cnt_q;
    chop_busy_d = chop_busy;
    meas_begin_d = 1'b0;
    // a request during a wait is absorbed by the wait in progress
    if (chop_busy) begin
      if (mod_tick) begin
        chop_cnt_d = chop_cnt_q - CCD_CHOP_UNIT;
        if (chop_cnt_q == CCD_CHOP_UNIT) begin
          chop_busy_d = 1'b0;
          meas_begin_d = 1'b1;
        end
      end
    end else if (meas_req) begin
      if (cfg_q[CCD_CHOP_EN_BIT]) begin
        chop_cnt_d = chop_load;
        chop_busy_d = 1'b1;
      end else begin
        meas_begin_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      chop_cnt_q <= '0;
      chop_busy <= 1'b0;
      meas_begin <= 1'b0;
    end else if (clk_en) begin
      chop_cnt_q <= chop_cnt_d;
      chop_busy <= chop_busy_d;
      meas_begin <= meas_begin_d;
    end
  end

  // ----------------------------------------------------------------
  // detect engine
  // ----------------------------------------------------------------
  // fields to engine
  assign cfg_bus.en = cfg_q[CCD_DET_EN_BIT];
  assign cfg_bus.policy = cfg_q[CCD_POLICY_BIT];
  assign cfg_bus.hit_code = cfg_q[CCD_HIT_MSB:CCD_HIT_LSB];
  assign cfg_bus.win_code = cfg_q[CCD_WIN_MSB:CCD_WIN_LSB];
  assign cfg_bus.threshold = {th_up_q, th_lo_q};

  ccd_detect #(.NCH(NCH)) u_detect (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .cfg(cfg_bus.snk),
    .conv_valid(conv_valid),
    .ch_result(ch_result),
    .detect_q(detect_pulse),
    .window_end_q(window_end)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_cfg_reset_val: assert property ($past(reset) |-> cfg_q == CCD_CFG_RST)
    else $error("configuration word wrong after reset");
  a_chop_bypass_now: assert property (clk_en && meas_req && !chop_busy
      && !cfg_q[CCD_CHOP_EN_BIT] |=> meas_begin && !chop_busy)
    else $error("measurement delayed with chop off");
  a_chop_wait_load: assert property (clk_en && meas_req && !chop_busy
      && cfg_q[CCD_CHOP_EN_BIT] |=> chop_busy && !meas_begin && chop_cnt_q == $past(chop_load))
    else $error("chop wait not loaded");
  a_chop_no_early: assert property (clk_en && chop_busy
      && !(mod_tick && chop_cnt_q == 17'h00001) |=> !meas_begin)
    else $error("measurement began during chop wait");
  a_cfg_res_kept: assert property (clk_en && commit && avs_write && aligned
      && idx == CCD_IDX_CFG && avs_byteenable[1] |=> cfg_q[15:13] == $past(avs_writedata[15:13]))
    else $error("upper configuration bits not stored");
  a_th_upper_store: assert property (clk_en && commit && avs_write && aligned
      && idx == CCD_IDX_TH_UP && avs_byteenable[1:0] == 2'h3
      |=> th_up_q == $past(avs_writedata[15:0]))
    else $error("upper threshold word not stored");
endmodule : ccd_top
`default_nettype wire

// >>> inc/ccd_cfg_if.sv
// configuration fields handed from the register file to the detect engine
`timescale 1ns/1ps
`default_nettype none
interface ccd_cfg_if;
  logic en;
  logic policy;
  logic [2:0] hit_code;
  logic [2:0] win_code;
  logic [23:0] threshold;
  modport src (output en, output policy, output hit_code, output win_code, output threshold);
  modport snk (input en, input policy, input hit_code, input win_code, input threshold);
endinterface : ccd_cfg_if
`default_nettype wire

// >>> inc/ccd_pkg.sv
// shared constants for the chop and current-detect configuration block
package ccd_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int CCD_ADDR_W = 8;
  localparam logic [5:0] CCD_IDX_SPARE = 6'h05;
  localparam logic [5:0] CCD_IDX_CFG = 6'h06;
  localparam logic [5:0] CCD_IDX_TH_UP = 6'h07;
  localparam logic [5:0] CCD_IDX_TH_LO = 6'h08;
  localparam logic [5:0] CCD_IDX_STAT = 6'h10;
  // ----------------------------------------------------------------
  // configuration word fields
  // ----------------------------------------------------------------
  localparam int CCD_RES_MSB = 15;
  localparam int CCD_RES_LSB = 13;
  localparam int CCD_DLY_MSB = 12;
  localparam int CCD_DLY_LSB = 9;
  localparam int CCD_CHOP_EN_BIT = 8;
  localparam int CCD_POLICY_BIT = 7;
  localparam int CCD_HIT_MSB = 6;
  localparam int CCD_HIT_LSB = 4;
  localparam int CCD_WIN_MSB = 3;
  localparam int CCD_WIN_LSB = 1;
  localparam int CCD_DET_EN_BIT = 0;
  // lower threshold byte sits in the top byte of its word
  localparam int CCD_TH_LO_LSB = 8;
  // status word bits
  localparam int CCD_ST_DET_BIT = 0;
  localparam int CCD_ST_BUSY_BIT = 1;
  localparam int CCD_ST_ACT_BIT = 2;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CCD_CFG_RST = 16'h0600;
  localparam logic [15:0] CCD_SPARE_RST = 16'h0000;
  localparam logic [15:0] CCD_TH_UP_RST = 16'h0000;
  localparam logic [7:0] CCD_TH_LO_RST = 8'h00;
  // ----------------------------------------------------------------
  // timing: chop wait is 2^(code+1) modulator periods, window table
  // ----------------------------------------------------------------
  localparam int CCD_CHOP_CNT_W = 17;
  localparam logic [16:0] CCD_CHOP_UNIT = 17'h00001;
  localparam logic [7:0][11:0] CCD_WIN_TAB = {12'he00, 12'ha00, 12'h700, 12'h500,
                                              12'h300, 12'h200, 12'h100, 12'h080};
  localparam logic [7:0] CCD_HIT_UNIT = 8'h01;
  localparam int CCD_RES_W = 24;
endpackage : ccd_pkg

// >>> testbench/chop_and_current_detect_config_bench.sv
// self-checking bench for the chop and current-detect configuration block
`timescale 1ns/1ps
`default_nettype none
module chop_and_current_detect_config_bench;
  import ccd_pkg::*;
  // ----------------------------------------------------------------
  // stimulus signals and counters
  // ----------------------------------------------------------------
  localparam logic [23:0] HI = 24'h001001;
  localparam logic [23:0] EQ = 24'h001000;
  localparam logic [23:0] NEG = 24'hffefff;
  localparam logic [23:0] LO = 24'h000010;
  localparam int WIN [8] = '{128, 256, 512, 768, 1280, 1792, 2560, 3584};
  logic clk_sys = 1'h0;
  logic reset = 1'h1;
  logic clk_en = 1'h1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h3;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic mod_tick = 1'h0;
  logic meas_req = 1'h0;
  logic conv_valid = 1'h0;
  logic [95:0] ch_result = 96'h0;
  logic meas_begin;
  logic chop_busy;
  logic detect_pulse;
  logic window_end;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;

  ccd_top #(.NCH(4)) dut (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mod_tick(mod_tick), .meas_req(meas_req),
    .conv_valid(conv_valid), .ch_result(ch_result), .meas_begin(meas_begin),
    .chop_busy(chop_busy), .detect_pulse(detect_pulse), .window_end(window_end)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'h1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  // request held until waitrequest is sampled low; only the run watchdog ends a hang
  task automatic bus(input logic wr_n, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_write <= wr_n;
    avs_read <= ~wr_n;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    chk(n == 2, "bus answer latency");
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] x;
    bus(1'h1, a, d, x);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] x;
    bus(1'h0, a, 16'h0, x);
    chk(x === e, m);
  endtask : rd_chk

  task automatic conv(input logic [95:0] r, output logic det, output logic wend);
    @(posedge clk_sys);
    ch_result <= r;
    conv_valid <= 1'h1;
    @(posedge clk_sys);
    conv_valid <= 1'h0;
    #1;
    det = detect_pulse;
    wend = window_end;
  endtask : conv

  // clearing the enable first restarts the window and hit counters
  task automatic det_cfg(input logic [15:0] c);
    wr(8'h18, 16'h0000);
    wr(8'h18, c);
  endtask : det_cfg

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_regs();
    rd_chk(8'h18, 32'h00000600, "cfg reset value");
    rd_chk(8'h14, 32'h00000000, "spare reset value");
    rd_chk(8'h1c, 32'h00000000, "threshold upper reset");
    wr(8'h18, 16'he5a4);
    rd_chk(8'h18, 32'h0000e5a4, "cfg readback with top bits");
    avs_byteenable <= 4'h1;
    wr(8'h18, 16'h1234);
    avs_byteenable <= 4'h3;
    rd_chk(8'h18, 32'h0000e534, "cfg low lane only");
    wr(8'h19, 16'hffff);
    rd_chk(8'h18, 32'h0000e534, "unaligned write ignored");
    rd_chk(8'h1a, 32'h00000000, "unaligned read");
    wr(8'h14, 16'h0000);
    rd_chk(8'h14, 32'h00000000, "spare after zero write");
    rd_chk(8'h3c, 32'h00000000, "unmapped read");
  endtask : test_regs

  task automatic chop_run(input logic [3:0] code, input logic en);
    int n;
    n = 0;
    wr(8'h18, {3'h0, code, en, 8'h00});
    @(posedge clk_sys);
    meas_req <= 1'h1;
    @(posedge clk_sys);
    meas_req <= 1'h0;
    mod_tick <= en;
    #1;
    if (en !== 1'h1) begin
      chk(meas_begin === 1'h1 && chop_busy === 1'h0, "chop off start");
    end else begin
      do begin
        @(posedge clk_sys);
        n++;
        #1;
        if (meas_begin !== 1'h1) chk(chop_busy === 1'h1, "chop busy held");
      end while (meas_begin !== 1'h1 && n < 100);
      mod_tick <= 1'h0;
      chk(n == (1 << (code + 1)), "chop wait length");
    end
  endtask : chop_run

  task automatic test_chop();
    chop_run(4'h0, 1'h0);
    chop_run(4'h0, 1'h1);
    chop_run(4'h1, 1'h1);
    chop_run(4'h3, 1'h1);
  endtask : test_chop

  task automatic test_detect();
    logic d;
    logic w;
    int n;
    wr(8'h1c, 16'h0010);
    wr(8'h20, 16'h0000);
    det_cfg(16'h0000);
    conv({4{HI}}, d, w);
    chk(d === 1'h0 && w === 1'h0, "detect while disabled");
    det_cfg(16'he001);
    conv({LO, LO, LO, EQ}, d, w);
    chk(d === 1'h0, "equal to threshold");
    conv({LO, NEG, LO, LO}, d, w);
    chk(d === 1'h1, "any channel detect");
    rd_chk(8'h40, 32'h00000005, "sticky detect flag");
    wr(8'h40, 16'h0001);
    rd_chk(8'h40, 32'h00000004, "detect flag cleared");
    det_cfg(16'h0081);
    conv({HI, HI, HI, LO}, d, w);
    chk(d === 1'h0, "all policy partial");
    conv({HI, NEG, HI, HI}, d, w);
    chk(d === 1'h1, "all policy full");
    det_cfg(16'h0021);
    for (int i = 0; i < 4; i++) begin
      conv({4{HI}}, d, w);
      chk(d === (i == 3), "hit count of four");
    end
    for (int c = 0; c < 4; c++) begin
      det_cfg({12'h000, c[2:0], 1'h1});
      for (int k = 1; k <= WIN[c]; k++) begin
        conv({4{LO}}, d, w);
        if (k >= WIN[c] - 1) chk(w === (k == WIN[c]), "window length");
      end
    end
    // long windows run with a conversion every cycle to keep the run short
    for (int c = 4; c < 8; c++) begin
      det_cfg({12'h000, c[2:0], 1'h1});
      n = 0;
      @(posedge clk_sys);
      conv_valid <= 1'h1;
      do begin
        @(posedge clk_sys);
        n++;
        #1;
      end while (window_end !== 1'h1 && n < 4000);
      @(posedge clk_sys);
      conv_valid <= 1'h0;
      chk(n == WIN[c], "long window length");
    end
  endtask : test_detect

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic results();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // the longest path is the window sweep, near 13000 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'h0;
    test_regs();
    test_chop();
    test_detect();
    results();
  end
endmodule : chop_and_current_detect_config_bench
`default_nettype wire
